// [shared/absb_pkg.sv]
// Package for the add/shift/bit/branch execution block of an 8-bit core
// Assumes the core decodes instructions into the operation codes below
package absb_pkg;
	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 7;
	localparam int BIT_W     = 3;
	localparam int PC_W      = 15;
	localparam int OFS_W     = 9;
	localparam int NIB_MSB   = 3;
	localparam int SIGN_BIT  = 7;
	localparam int DEST_ACC  = 0;
	localparam logic [PC_W-1:0]   PC_RESET   = 15'h0000;
	localparam logic [PC_W-1:0]   PC_STEP    = 15'h0001;
	localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic [4:0]        NIB_ZERO   = 5'h00;

	typedef enum logic [2:0] {
		ABSB_OP_NOP,
		ABSB_OP_ADD,
		ABSB_OP_ADDC,
		ABSB_OP_ASR,
		ABSB_OP_BCLR,
		ABSB_OP_BTSZ,
		ABSB_OP_RJMP
	} absb_op_type;
endpackage

// [src/absb_alu.sv]
// Combinational 8-bit arithmetic unit: add, add with carry, shift, bit clear
// Assumes the caller holds operands stable for the cycle it samples results
`timescale 1ns/1ns
module absb_alu (
	input  wire absb_pkg::absb_op_type  op_i,
	input  wire logic [7:0]             acc_i,
	input  wire logic [7:0]             file_i,
	input  wire logic                   carry_i,
	input  wire logic [2:0]             bit_sel_i,
	output logic      [7:0]             result_o,
	output logic                        carry_o,
	output logic                        half_o,
	output logic                        zero_o,
	output logic                        bit_val_o
);
	import absb_pkg::*;

	logic [DATA_W:0]  sum;
	logic [4:0]       nib;
	logic             cin;

	// Carry in only for the add-with-carry form
	assign cin = (op_i == ABSB_OP_ADDC) ? carry_i : 1'b0;
	// [RULE1] [RULE4] full sum
	assign sum = {1'b0, acc_i} + {1'b0, file_i} + {{DATA_W{1'b0}}, cin};
	// [RULE10] low nibble carry
	assign nib = NIB_ZERO + {1'b0, acc_i[NIB_MSB:0]} + {1'b0, file_i[NIB_MSB:0]}
		+ {4'h0, cin};
	assign bit_val_o = file_i[bit_sel_i];

	// Result and flag selection per operation
	always_comb begin
		result_o = file_i;
		carry_o  = carry_i;
		half_o   = nib[4];
		case (op_i)
			ABSB_OP_ADD, ABSB_OP_ADDC: begin
				result_o = sum[DATA_W-1:0];
				carry_o  = sum[DATA_W];
			end
			// [RULE3] sign kept, bit 0 to carry
			ABSB_OP_ASR: begin
				result_o = {file_i[SIGN_BIT], file_i[DATA_W-1:1]};
				carry_o  = file_i[0];
			end
			// [RULE5] clear selected bit
			ABSB_OP_BCLR: result_o = file_i & ~(8'h01 << bit_sel_i);
			default: result_o = file_i;
		endcase
	end

	// [RULE10] zero flag
	assign zero_o = (result_o == ZERO_BYTE);
endmodule

// [src/absb_exec.sv]
// Execution stage for add, carry add, shift right, bit clear, skip and jump
// Assumes one instruction offered per enabled cycle; file memory lives outside
// Assumes the file read data belongs to file_addr_i in the same cycle
// Assumes the fetch stage drops its next word whenever flush_o is high
// The program counter counts words and wraps silently at the top
// How it works
// [RULE1] Add accumulator to file register, flags C,DC,Z
// [RULE2] Destination 0 to accumulator, 1 to file
// [RULE3] Shift right keeping sign, bit0 into carry
// [RULE4] Add with carry, flags C,DC,Z, selectable destination
// [RULE5] Clear one file bit, flags untouched
// [RULE6] Skip next when tested bit is zero
// [RULE7] Jump to next PC plus signed offset
// [RULE8] Relative jump always takes two cycles
// [RULE9] Taken skip or PC change: second cycle NOP
// [RULE10] DC from bit 3 carry, Z on zero
`timescale 1ns/1ns
module absb_exec (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   instr_valid_i,
	input  wire absb_pkg::absb_op_type  op_i,
	input  wire logic [6:0]             file_addr_i,
	input  wire logic                   dest_i,
	input  wire logic [2:0]             bit_sel_i,
	input  wire logic [8:0]             offset_i,
	input  wire logic [7:0]             file_rdata_i,
	output logic                        busy_o,
	output logic      [7:0]             acc_o,
	output logic                        carry_o,
	output logic                        half_byte_carry_o,
	output logic                        zero_o,
	output logic      [14:0]            program_counter_o,
	output logic                        file_we_o,
	output logic      [6:0]             file_waddr_o,
	output logic      [7:0]             file_wdata_o,
	output logic                        flush_o
);
	import absb_pkg::*;

	typedef enum logic {ABSB_RUN, ABSB_BUBBLE} absb_state_type;

	absb_state_type    state_r;
	absb_state_type    state_nxt;
	logic [DATA_W-1:0] alu_res;
	logic              alu_c;
	logic              alu_dc;
	logic              alu_z;
	logic              alu_bit;
	logic              go;
	logic              is_arith;
	logic              take_two;
	logic              is_add;
	logic              is_addc;
	logic              is_shift;
	logic              is_clear;
	logic              is_jump;
	logic              acc_we;
	logic              file_we_nxt;
	logic              flag_we;
	logic              half_we;
	logic              pc_jump;
	logic              pc_step;
	logic [PC_W-1:0]   pc_inc;
	logic [PC_W-1:0]   ofs_ext;

	absb_alu u_alu (
		.op_i      (op_i),
		.acc_i     (acc_o),
		.file_i    (file_rdata_i),
		.carry_i   (carry_o),
		.bit_sel_i (bit_sel_i),
		.result_o  (alu_res),
		.carry_o   (alu_c),
		.half_o    (alu_dc),
		.zero_o    (alu_z),
		.bit_val_o (alu_bit)
	);

	// Operation decode; NOP and unused codes leave every write enable low, but go still steps the counter
	assign is_add   = (op_i == ABSB_OP_ADD);
	assign is_addc  = (op_i == ABSB_OP_ADDC);
	assign is_shift = (op_i == ABSB_OP_ASR);
	assign is_clear = (op_i == ABSB_OP_BCLR);
	assign is_jump  = (op_i == ABSB_OP_RJMP);
	assign is_arith = is_add || is_addc || is_shift;

	// Instructions are only accepted outside the discarded second cycle
	assign go       = ce_i && instr_valid_i && (state_r == ABSB_RUN);
	assign busy_o   = (state_r == ABSB_BUBBLE);

	// Write enables per concern; all hang off go, so a low ce_i freezes them
	// [RULE2] destination select
	assign acc_we      = go && is_arith && (dest_i == DEST_ACC[0]);
	// [RULE5] clear writes back
	assign file_we_nxt = go && ((is_arith && (dest_i != DEST_ACC[0])) || is_clear);
	// [RULE1] [RULE4] arithmetic flag update
	assign flag_we     = go && is_arith;
	// [RULE3] shift skips half-byte carry
	assign half_we     = flag_we && !is_shift;

	// Counter sources; the offset is sign extended to the counter width
	// [RULE7] signed offset
	assign ofs_ext = {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};
	assign pc_inc  = program_counter_o + PC_STEP;
	assign pc_jump = go && is_jump;
	// Bubble cycles step too, so the counter keeps pace with the fetch stage
	assign pc_step = go || (ce_i && busy_o);

	// [RULE6] [RULE8] [RULE9] two-cycle decision
	always_comb begin
		take_two = 1'b0;
		case (op_i)
			ABSB_OP_BTSZ: take_two = ~alu_bit;
			ABSB_OP_RJMP: take_two = 1'b1;
			default:      take_two = 1'b0;
		endcase
	end

	// Second cycle runs as a no-operation; the fetched word is thrown away
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ABSB_RUN:    state_nxt = (go && take_two) ? ABSB_BUBBLE : ABSB_RUN;
			ABSB_BUBBLE: state_nxt = ABSB_RUN;
			default:     state_nxt = ABSB_RUN;
		endcase
	end

	// State register; a low ce_i holds a pending bubble
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ABSB_RUN;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Flush is combinational so the fetch stage drops the word this cycle
	assign flush_o = go && take_two;

	// [RULE2] accumulator destination
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_o <= ACC_RESET;
		end else if (acc_we) begin
			acc_o <= alu_res;
		end
	end

	// [RULE2] file destination; bit clear always writes back
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			file_we_o    <= 1'b0;
			file_waddr_o <= 7'h00;
			file_wdata_o <= ZERO_BYTE;
		end else if (ce_i) begin
			file_we_o    <= file_we_nxt;
			file_waddr_o <= file_addr_i;
			file_wdata_o <= alu_res;
		end
	end

	// [RULE1] [RULE4] [RULE10] flag update
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			carry_o           <= 1'b0;
			half_byte_carry_o <= 1'b0;
			zero_o            <= 1'b0;
		end else if (flag_we) begin
			carry_o <= alu_c;
			zero_o  <= alu_z;
			// [RULE3] shift leaves half-byte carry alone
			if (half_we) begin
				half_byte_carry_o <= alu_dc;
			end
		end
	end

	// [RULE7] PC plus one plus signed offset; PC also steps through bubbles
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			program_counter_o <= PC_RESET;
		end else if (pc_jump) begin
			program_counter_o <= pc_inc + ofs_ext;
		end else if (pc_step) begin
			program_counter_o <= pc_inc;
		end
	end
endmodule

// [sim/absb_exec_chk.sv]
// Assertions on the ports of the execution block
// Assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ns
module absb_exec_chk (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  ce_i,
	input wire logic                  instr_valid_i,
	input wire absb_pkg::absb_op_type op_i,
	input wire logic [6:0]            file_addr_i,
	input wire logic                  dest_i,
	input wire logic [2:0]            bit_sel_i,
	input wire logic [8:0]            offset_i,
	input wire logic [7:0]            file_rdata_i,
	input wire logic                  busy_o,
	input wire logic [7:0]            acc_o,
	input wire logic                  carry_o,
	input wire logic                  half_byte_carry_o,
	input wire logic                  zero_o,
	input wire logic [14:0]           program_counter_o,
	input wire logic                  file_we_o,
	input wire logic [6:0]            file_waddr_o,
	input wire logic                  flush_o
);
	import absb_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Accepted instruction and the flag group
	wire tk = ce_i && instr_valid_i && !busy_o;
	wire [2:0] fl = {carry_o, half_byte_carry_o, zero_o};
	jump_flush_a: assert property (tk && op_i == ABSB_OP_RJMP |-> flush_o)
		else $error("jump without flush");
	jump_target_a: assert property (tk && op_i == ABSB_OP_RJMP |=> busy_o &&
		program_counter_o == $past(program_counter_o) + 15'h1 +
		{{6{$past(offset_i[8])}}, $past(offset_i)}) else $error("jump target");
	jump_flags_a: assert property (tk && op_i == ABSB_OP_RJMP |=> $stable(fl))
		else $error("jump moved flags");
	clear_flags_a: assert property (tk && op_i == ABSB_OP_BCLR |=> $stable(fl))
		else $error("bit clear moved flags");
	file_dest_a: assert property (tk && dest_i && op_i inside {ABSB_OP_ADD,
		ABSB_OP_ADDC, ABSB_OP_ASR} |=> file_we_o && $stable(acc_o) &&
		file_waddr_o == $past(file_addr_i)) else $error("file destination");
	skip_flush_a: assert property (tk && op_i == ABSB_OP_BTSZ |->
		flush_o == !file_rdata_i[bit_sel_i]) else $error("skip decision");
	bubble_one_a: assert property (busy_o && ce_i |=> !busy_o)
		else $error("bubble too long");
	shift_sign_a: assert property (tk && op_i == ABSB_OP_ASR && !dest_i |=>
		acc_o == {$past(file_rdata_i[7]), $past(file_rdata_i[7:1])} &&
		carry_o == $past(file_rdata_i[0])) else $error("shift result");
endmodule
bind absb_exec absb_exec_chk chk_u (.clk_i, .rst_i, .ce_i, .instr_valid_i, .op_i,
	.file_addr_i, .dest_i, .bit_sel_i, .offset_i, .file_rdata_i, .busy_o, .acc_o,
	.carry_o, .half_byte_carry_o, .zero_o, .program_counter_o, .file_we_o,
	.file_waddr_o, .flush_o);

// [sim/add_shift_bit_branch_exec_tb.sv]
// Self-checking bench for the execution block
// Assumes file reads answer in the same cycle; file address held at 127
`timescale 1ns/1ns
module add_shift_bit_branch_exec_tb;
	import absb_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, instr_valid_i = 1'b0, dest_i = 1'b0;
	absb_op_type op_i = ABSB_OP_NOP;
	logic [6:0] file_addr_i = 7'h7f, file_waddr_o;
	logic [2:0] bit_sel_i = 3'h0;
	logic [8:0] offset_i = 9'h000;
	logic [7:0] file_rdata_i = 8'h00, acc_o, file_wdata_o;
	logic busy_o, carry_o, half_byte_carry_o, zero_o, file_we_o, flush_o, fl;
	logic [14:0] program_counter_o;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	absb_exec dut_u (.clk_i, .rst_i, .ce_i, .instr_valid_i, .op_i, .file_addr_i, .dest_i,
		.bit_sel_i, .offset_i, .file_rdata_i, .busy_o, .acc_o, .carry_o,
		.half_byte_carry_o, .zero_o, .program_counter_o, .file_we_o, .file_waddr_o,
		.file_wdata_o, .flush_o);
	always #5 clk_i = ~clk_i;
	// Hang guard; the run needs under fifty cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 400) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic cmp(input string n, input logic [14:0] e, input logic [14:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Offer one instruction, note flush, return after the taking edge
	task automatic issue(input absb_op_type o, input logic [7:0] f, input logic [2:0] b,
		input logic d, input logic [8:0] k);
		@(posedge clk_i);
		op_i         <= o;
		file_rdata_i <= f;
		bit_sel_i    <= b;
		dest_i       <= d;
		offset_i     <= k;
		instr_valid_i <= 1'b1;
		#1 fl = flush_o;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
	endtask
	task automatic t_arith;
		issue(ABSB_OP_ADD, 8'h8f, 3'h0, 1'b0, 9'h0);
		cmp("acc", 15'h8f, acc_o);
		issue(ABSB_OP_ADD, 8'h71, 3'h0, 1'b0, 9'h0);
		cmp("flags", 15'h7, {acc_o, carry_o, half_byte_carry_o, zero_o});
		issue(ABSB_OP_ADDC, 8'h0e, 3'h0, 1'b1, 9'h0);
		cmp("wdata", 15'h10f, {file_we_o, file_wdata_o});
		cmp("waddr", 15'h7f, file_waddr_o);
		cmp("acc", 15'h0, {acc_o, carry_o, half_byte_carry_o, zero_o});
		issue(ABSB_OP_ASR, 8'h81, 3'h0, 1'b0, 9'h0);
		cmp("shift", 15'h604, {acc_o, carry_o, half_byte_carry_o, zero_o});
		issue(ABSB_OP_BCLR, 8'hff, 3'h7, 1'b1, 9'h0);
		cmp("clear", 15'h17f, {file_we_o, file_wdata_o});
		cmp("clear flags", 15'h4, {carry_o, half_byte_carry_o, zero_o});
	endtask
	// Clock enable low: an offered add must change nothing
	task automatic t_freeze;
		@(posedge clk_i);
		ce_i <= 1'b0;
		issue(ABSB_OP_ADD, 8'h01, 3'h0, 1'b0, 9'h0);
		cmp("frozen", 15'h604, {acc_o, carry_o, half_byte_carry_o, zero_o});
		cmp("frozen pc", 15'h5, program_counter_o);
		@(posedge clk_i);
		ce_i <= 1'b1;
	endtask
	// Reset in mid-run: accumulator, flags, busy, write enable and counter back to their reset values
	task automatic t_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		cmp("rst state", 15'h0, {acc_o, carry_o, half_byte_carry_o, zero_o, busy_o, file_we_o});
		cmp("rst pc", 15'h0, program_counter_o);
		@(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// Both skip outcomes, then jumps to both ends of the offset range; counter starts at reset
	task automatic t_flow;
		issue(ABSB_OP_BTSZ, 8'hfe, 3'h1, 1'b0, 9'h0);
		cmp("noskip", 15'h0, {fl, busy_o});
		cmp("pc", 15'h1, program_counter_o);
		issue(ABSB_OP_BTSZ, 8'hfe, 3'h0, 1'b0, 9'h0);
		cmp("skip", 15'h3, {fl, busy_o});
		issue(ABSB_OP_RJMP, 8'h0, 3'h0, 1'b0, 9'h100);
		cmp("pc", 15'h7f04, program_counter_o);
		cmp("jump", 15'h3, {fl, busy_o});
		issue(ABSB_OP_RJMP, 8'h0, 3'h0, 1'b0, 9'h0ff);
		cmp("pc", 15'h0005, program_counter_o);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_arith();
		t_freeze();
		t_reset();
		t_flow();
		complete_run();
	end
endmodule
